// ---- core/codec_dsp_channel_power_cfg.v ----
// Playback DSP, channel enable and dynamic power configuration registers
`timescale 1ns/100ps
`include "codec_dsp_channel_power_cfg_map.vh"

module codec_dsp_channel_power_cfg (
  // Clock and reset
  input  wire       i_core_clk,
  input  wire       i_srst,
  // Register access from the control port decoder
  input  wire [7:0] i_reg_addr,
  input  wire [7:0] i_reg_wdata,
  input  wire       i_reg_wr,
  input  wire       i_reg_rd,
  output reg  [7:0] o_reg_rdata,
  output reg        o_reg_rvalid,
  // Global power controls from the power config register
  input  wire       i_playback_global_power,
  input  wire       i_record_global_power,
  // Playback DSP settings
  output reg  [1:0] o_playback_filter_response,
  output reg  [1:0] o_playback_highpass_select,
  output reg  [1:0] o_playback_biquad_count,
  output reg        o_playback_soft_step_enable,
  output reg        o_playback_volume_gang,
  // Dynamic power settings
  output reg        o_dynamic_split_clock_select,
  // Applied channel power
  output wire [3:0] o_input_power,
  output wire [3:0] o_output_power
);

  // Reset images kept whole, so each field resets from the one constant it lives in
  localparam [7:0] DSP_RST       = `RST_PLAYBACK_DSP_CONFIG;
  localparam [7:0] CHAN_RST      = `RST_CHANNEL_ENABLE;
  localparam [7:0] DYN_RST       = `RST_DYNAMIC_POWER_CONFIG;

  // Sequencer slots; slot N owns channel enable bits 4N+3 down to 4N
  // Playback sits in slot 0 because its enables are the low nibble
  localparam       SLOT_PLAYBACK = 0;
  localparam       SLOT_RECORD   = 1;
  localparam       SLOT_COUNT    = 2;

  // Register storage and next values
  reg  [7:0] dsp_cfg_r;
  reg  [7:0] chan_en_r;
  reg  [7:0] dyn_cfg_r;
  reg  [7:0] dsp_cfg_nxt;
  reg  [7:0] chan_en_nxt;
  reg  [7:0] dyn_cfg_nxt;
  reg  [7:0] rdata_nxt;

  // Offset matches and write strobes
  wire       hit_dsp;
  wire       hit_chan;
  wire       hit_dyn;
  wire       wr_dsp;
  wire       wr_chan;
  wire       wr_dyn;

  // Next values of the setting outputs
  reg  [1:0] filter_nxt;
  reg  [1:0] highpass_nxt;
  reg  [1:0] biquad_nxt;
  reg        soft_step_nxt;
  reg        gang_nxt;
  reg        split_clock_nxt;

  // Per-slot controls and applied power of the sequencers
  wire [1:0] slot_global;
  wire [1:0] slot_dyn_enable;
  wire [1:0] slot_dyn_limit;
  wire [7:0] slot_power;

  // Address match, shared by write and read decode
  function reg_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  // Offset match per register; the read mux and the write strobes share these
  assign hit_dsp  = reg_hit(i_reg_addr, `ADDR_PLAYBACK_DSP_CONFIG);
  assign hit_chan = reg_hit(i_reg_addr, `ADDR_CHANNEL_ENABLE);
  assign hit_dyn  = reg_hit(i_reg_addr, `ADDR_DYNAMIC_POWER_CONFIG);

  // An unmapped offset raises no strobe, so such a write changes nothing
  assign wr_dsp  = i_reg_wr & hit_dsp;
  assign wr_chan = i_reg_wr & hit_chan;
  assign wr_dyn  = i_reg_wr & hit_dyn;

  // Next register values; each register moves only on a write to its own offset
  always @* begin
    dsp_cfg_nxt = dsp_cfg_r;
    chan_en_nxt = chan_en_r;
    dyn_cfg_nxt = dyn_cfg_r;
    if (wr_dsp) begin
      dsp_cfg_nxt = i_reg_wdata;
    end
    if (wr_chan) begin
      chan_en_nxt = i_reg_wdata;
    end
    if (wr_dyn) begin
      // Masking keeps a careless write from disturbing the reserved bits
      dyn_cfg_nxt = (i_reg_wdata & `DYN_WRITABLE_MASK) | `DYN_RESERVED_VALUE;
    end
  end

  // Register storage
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      dsp_cfg_r <= DSP_RST;
      chan_en_r <= CHAN_RST;
      dyn_cfg_r <= DYN_RST;
    end else begin
      dsp_cfg_r <= dsp_cfg_nxt;
      chan_en_r <= chan_en_nxt;
      dyn_cfg_r <= dyn_cfg_nxt;
    end
  end

  // Read mux; unmapped offsets read as zero
  always @* begin
    rdata_nxt = 8'h00;
    if (hit_dsp) begin
      rdata_nxt = dsp_cfg_r;
    end else if (hit_chan) begin
      rdata_nxt = chan_en_r;
    end else if (hit_dyn) begin
      rdata_nxt = dyn_cfg_r;
    end
  end

  // Registered read answer, one cycle after the read strobe
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_nxt;
      end
    end
  end

  // Field decode of the settings; filter code 3 passes through and software must avoid it
  always @* begin
    filter_nxt      = dsp_cfg_r[`DSP_FILT_MSB:`DSP_FILT_LSB];
    highpass_nxt    = dsp_cfg_r[`DSP_HPF_MSB:`DSP_HPF_LSB];
    biquad_nxt      = dsp_cfg_r[`DSP_BQ_MSB:`DSP_BQ_LSB];
    soft_step_nxt   = ~dsp_cfg_r[`DSP_SOFT_STEP_DIS_BIT];
    gang_nxt        = dsp_cfg_r[`DSP_VOL_GANG_BIT];
    split_clock_nxt = dyn_cfg_r[`DYN_SPLIT_CLK_BIT];
  end

  // Setting outputs, registered so they follow a write one edge after it lands
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_playback_filter_response   <= DSP_RST[`DSP_FILT_MSB:`DSP_FILT_LSB];
      o_playback_highpass_select   <= DSP_RST[`DSP_HPF_MSB:`DSP_HPF_LSB];
      o_playback_biquad_count      <= DSP_RST[`DSP_BQ_MSB:`DSP_BQ_LSB];
      o_playback_soft_step_enable  <= ~DSP_RST[`DSP_SOFT_STEP_DIS_BIT];
      o_playback_volume_gang       <= DSP_RST[`DSP_VOL_GANG_BIT];
      o_dynamic_split_clock_select <= DYN_RST[`DYN_SPLIT_CLK_BIT];
    end else begin
      o_playback_filter_response   <= filter_nxt;
      o_playback_highpass_select   <= highpass_nxt;
      o_playback_biquad_count      <= biquad_nxt;
      o_playback_soft_step_enable  <= soft_step_nxt;
      o_playback_volume_gang       <= gang_nxt;
      o_dynamic_split_clock_select <= split_clock_nxt;
    end
  end

  // Per-slot controls, indexed so the generate loop below needs no path cases
  assign slot_global[SLOT_PLAYBACK]     = i_playback_global_power;
  assign slot_global[SLOT_RECORD]       = i_record_global_power;
  assign slot_dyn_enable[SLOT_PLAYBACK] = dyn_cfg_r[`DYN_PLAY_EN_BIT];
  assign slot_dyn_enable[SLOT_RECORD]   = dyn_cfg_r[`DYN_REC_EN_BIT];
  assign slot_dyn_limit[SLOT_PLAYBACK]  = dyn_cfg_r[`DYN_PLAY_LIMIT_BIT];
  assign slot_dyn_limit[SLOT_RECORD]    = dyn_cfg_r[`DYN_REC_LIMIT_BIT];

  // One sequencer per path; both follow the same rules, only their controls differ
  genvar slot;
  generate
    for (slot = 0; slot < SLOT_COUNT; slot = slot + 1) begin : g_path
      // Enable slice and power slice sit at the same bit positions
      channel_power_seq u_power (
        .i_core_clk       (i_core_clk),
        .i_srst           (i_srst),
        .i_global_power   (slot_global[slot]),
        .i_channel_enable (chan_en_r[4*slot +: 4]),
        .i_dynamic_enable (slot_dyn_enable[slot]),
        .i_dynamic_limit  (slot_dyn_limit[slot]),
        .o_power          (slot_power[4*slot +: 4])
      );
    end
  endgenerate

  // Applied power comes straight from the sequencer flops
  assign o_output_power = slot_power[`CHEN_OUTPUT_MSB:`CHEN_OUTPUT_LSB];
  assign o_input_power  = slot_power[`CHEN_INPUT_MSB:`CHEN_INPUT_LSB];

endmodule // codec_dsp_channel_power_cfg

// ---- inc/codec_dsp_channel_power_cfg_map.vh ----
// Register offsets, field positions and reset values of the channel power config group
`ifndef CODEC_DSP_CHANNEL_POWER_CFG_MAP_VH
`define CODEC_DSP_CHANNEL_POWER_CFG_MAP_VH

// Register offsets on the control port
`define ADDR_PLAYBACK_DSP_CONFIG   8'h73
`define ADDR_CHANNEL_ENABLE        8'h76
`define ADDR_DYNAMIC_POWER_CONFIG  8'h77

// Reset values
`define RST_PLAYBACK_DSP_CONFIG    8'h18
`define RST_CHANNEL_ENABLE         8'hCC
`define RST_DYNAMIC_POWER_CONFIG   8'h00

// Playback DSP config fields
`define DSP_FILT_MSB               7
`define DSP_FILT_LSB               6
`define DSP_HPF_MSB                5
`define DSP_HPF_LSB                4
`define DSP_BQ_MSB                 3
`define DSP_BQ_LSB                 2
`define DSP_SOFT_STEP_DIS_BIT      1
`define DSP_VOL_GANG_BIT           0

// Channel enable fields
`define CHEN_INPUT_MSB             7
`define CHEN_INPUT_LSB             4
`define CHEN_OUTPUT_MSB            3
`define CHEN_OUTPUT_LSB            0

// Dynamic power config fields
`define DYN_REC_EN_BIT             7
`define DYN_REC_LIMIT_BIT          6
`define DYN_PLAY_EN_BIT            5
`define DYN_PLAY_LIMIT_BIT         4
`define DYN_SPLIT_CLK_BIT          3
`define DYN_WRITABLE_MASK          8'hF8
`define DYN_RESERVED_VALUE         8'h00

// Channel masks for dynamic operation; channel one is the top bit of each group
`define DYN_MASK_TWO               4'hC
`define DYN_MASK_FOUR              4'hF

`endif

// ---- core/channel_power_seq.v ----
// Per-path channel power sequencer: global power, enables and dynamic rules
`timescale 1ns/100ps
`include "codec_dsp_channel_power_cfg_map.vh"

module channel_power_seq (
  // Clock and reset
  input  wire       i_core_clk,
  input  wire       i_srst,
  // Controls
  input  wire       i_global_power,
  input  wire [3:0] i_channel_enable,
  input  wire       i_dynamic_enable,
  input  wire       i_dynamic_limit,
  // Applied channel power
  output reg  [3:0] o_power
);

  wire       running;
  wire [3:0] dyn_mask;
  reg  [3:0] power_nxt;

  assign running  = |o_power;
  assign dyn_mask = i_dynamic_limit ? `DYN_MASK_FOUR : `DYN_MASK_TWO;

  // Next channel power; channels outside the dynamic range keep their state
  always @* begin
    power_nxt = o_power;
    if (!i_global_power) begin
      power_nxt = 4'h0;
    end else if (!running) begin
      power_nxt = i_channel_enable;
    end else if (i_dynamic_enable) begin
      power_nxt = (i_channel_enable & dyn_mask) | (o_power & ~dyn_mask);
    end
  end

  // Power state register
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_power <= 4'h0;
    end else begin
      o_power <= power_nxt;
    end
  end

endmodule // channel_power_seq

// ---- test/cfg_props.sv ----
// Port assertions for the channel power config block
`timescale 1ns/100ps
module cfg_props (
  input logic       i_core_clk,
  input logic       i_srst,
  input logic [7:0] i_reg_addr,
  input logic [7:0] i_reg_wdata,
  input logic       i_reg_wr,
  input logic       i_reg_rd,
  input logic [7:0] o_reg_rdata,
  input logic       o_reg_rvalid,
  input logic       i_playback_global_power,
  input logic [1:0] o_playback_filter_response,
  input logic       o_playback_soft_step_enable,
  input logic       o_playback_volume_gang,
  input logic       o_dynamic_split_clock_select,
  input logic [3:0] o_output_power
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // A write lands in the register, the setting output follows one edge later
  sequence dsp_wr; i_reg_wr && i_reg_addr == 8'h73 ##2 1; endsequence
  sequence dyn_wr; i_reg_wr && i_reg_addr == 8'h77 ##2 1; endsequence
  read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  read_quiet_a: assert property (!i_reg_rd |=> !o_reg_rvalid)
    else $error("stray read valid");
  filter_field_a: assert property (dsp_wr |->
    o_playback_filter_response == $past(i_reg_wdata[7:6], 2)) else $error("filter");
  soft_step_a: assert property (dsp_wr |->
    o_playback_soft_step_enable == !$past(i_reg_wdata[1], 2)) else $error("soft step");
  volume_gang_a: assert property (dsp_wr |->
    o_playback_volume_gang == $past(i_reg_wdata[0], 2)) else $error("gang");
  split_clock_a: assert property (dyn_wr |->
    o_dynamic_split_clock_select == $past(i_reg_wdata[3], 2)) else $error("split");
  reserved_zero_a: assert property (i_reg_rd && i_reg_addr == 8'h77 |=>
    o_reg_rdata[2:0] == 3'h0) else $error("reserved bits");
  play_off_a: assert property (!i_playback_global_power |=>
    o_output_power == 4'h0) else $error("playback power");
endmodule // cfg_props

bind codec_dsp_channel_power_cfg cfg_props u_props (.*);

// ---- test/tb_codec_dsp_channel_power_cfg.sv ----
// Self-checking bench for the channel power config registers
`timescale 1ns/100ps
module tb_codec_dsp_channel_power_cfg;
  logic       i_core_clk = 0;
  logic       i_srst = 1;
  logic       i_reg_wr = 0;
  logic       i_reg_rd = 0;
  logic       i_playback_global_power = 0;
  logic       i_record_global_power = 0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  wire  [7:0] o_reg_rdata;
  wire        o_reg_rvalid, o_playback_soft_step_enable, o_playback_volume_gang;
  wire        o_dynamic_split_clock_select;
  wire  [1:0] o_playback_filter_response, o_playback_highpass_select, o_playback_biquad_count;
  wire  [3:0] o_input_power, o_output_power;
  int         bad_count = 0;
  int         compares = 0;
  // Settings reassembled in register layout so one compare covers all fields
  wire  [7:0] dsp_view = {o_playback_filter_response, o_playback_highpass_select,
                          o_playback_biquad_count, ~o_playback_soft_step_enable,
                          o_playback_volume_gang};
  always #10 i_core_clk = ~i_core_clk;
  codec_dsp_channel_power_cfg u_dut (.*);
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes rise and fall on falling edges, one pulse per access
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk) {i_reg_addr, i_reg_wdata, i_reg_wr} = {a, d, 1'b1};
    @(negedge i_core_clk) i_reg_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_core_clk) {i_reg_addr, i_reg_rd} = {a, 1'b1};
    @(negedge i_core_clk) i_reg_rd = 0;
    chk({7'h00, o_reg_rvalid}, 8'h01);
    chk(o_reg_rdata, exp);
  endtask
  // Power is a level, so a few cycles of settling cost nothing
  task pw(input logic [7:0] exp);
    repeat (3) @(negedge i_core_clk);
    chk({o_input_power, o_output_power}, exp);
  endtask
  task t_reset;
    chk(dsp_view, 8'h18);
    rd(8'h73, 8'h18);
    rd(8'h76, 8'hCC);
    rd(8'h77, 8'h00);
  endtask
  // Filter code 3 is reserved, so the last pattern keeps the filter at 2
  task t_dsp;
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      v = (k == 3) ? 8'hBF : 8'h55 * k[7:0];
      wr(8'h73, v);
      rd(8'h73, v);
      chk(dsp_view, v);
    end
  endtask
  // Reserved bits are written as zero; an unmapped offset must not stick
  task t_dyn;
    wr(8'h77, 8'hF8);
    rd(8'h77, 8'hF8);
    chk({7'h00, o_dynamic_split_clock_select}, 8'h01);
    wr(8'h74, 8'h5A);
    rd(8'h74, 8'h00);
    rd(8'h73, 8'hBF);
    wr(8'h77, 8'h00);
  endtask
  task t_power;
    wr(8'h76, 8'h3A);
    @(negedge i_core_clk) {i_playback_global_power, i_record_global_power} = 2'b11;
    pw(8'h3A);
    wr(8'h76, 8'h5F);
    pw(8'h3A);
    wr(8'h77, 8'hA0);
    pw(8'h7E);
    wr(8'h77, 8'hF0);
    pw(8'h5F);
    @(negedge i_core_clk) {i_playback_global_power, i_record_global_power} = 2'b00;
    pw(8'h00);
  endtask
  task test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge i_core_clk);
    i_srst = 0;
    t_reset;
    t_dsp;
    t_dyn;
    t_power;
    test_done;
  end
  // Watchdog well past the 64 or so cycles the run needs
  initial begin
    #20000;
    bad_count++;
    test_done;
  end
endmodule // tb_codec_dsp_channel_power_cfg
